// >>> rtl/status_led_indicator.sv
// Purpose: Drives the four front-panel diagnostic lamps of the encoder input module.
// Assumes: 200 MHz clock; period, error and state inputs come from same-clock logic;
//          the reference mark input comes from a pin.
// Notes: Every lamp output is a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module status_led_indicator
#(
   parameter int unsigned FLASH_CYCLES = status_led_pkg::FLASH_HALF_CYCLES,
   parameter int unsigned FLICKER_CYCLES = status_led_pkg::FLICKER_HALF_CYCLES,
   parameter int unsigned SINGLE_SLOTS = status_led_pkg::SINGLE_SLOTS
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic period_counted,
   input wire logic ref_mark,
   input wire logic pdo_error,
   input wire logic [3:0] slave_state,
   output logic period_lamp,
   output logic ref_lamp,
   output logic error_lamp,
   output logic run_lamp,
   output logic outputs_safe
);
   import status_led_pkg::*;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   // Single flash needs at least one dark slot after the lit one, and the
   // slot counter is eight bits wide; other values are refused at elaboration.
   if (SINGLE_SLOTS < 2 || SINGLE_SLOTS > 255)
   begin
      $error("status_led_indicator: SINGLE_SLOTS must be 2 to 255");
   end

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   // One-cycle ticks marking flash and flicker half periods.
   logic flash_tick;
   logic flicker_tick;

   blink_timebase #(
      .FLASH_CYCLES(FLASH_CYCLES),
      .FLICKER_CYCLES(FLICKER_CYCLES)
   ) u_timebase (
      .clk(clk),
      .rst_n(rst_n),
      .flash_tick(flash_tick),
      .flicker_tick(flicker_tick)
   );

   // ----------------------------------------------------------------
   // Reference input synchroniser
   // ----------------------------------------------------------------
   // The first stage is read only by the second stage.
   logic ref_meta;
   logic ref_sync;

   // Two flip-flops bring the pin into the clock domain.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
      end
      else
      begin
         ref_meta <= ref_mark;
         ref_sync <= ref_meta;
      end
   end

   // ----------------------------------------------------------------
   // Pattern phases
   // ----------------------------------------------------------------
   // Square-wave phases and the single-flash slot counter.
   logic flash_phase;
   logic next_flash_phase;
   logic flicker_phase;
   logic next_flicker_phase;
   logic [7:0] slot;
   logic [7:0] next_slot;

   // Next phases: each tick flips its square wave; the flash tick also steps the slot.
   always_comb
   begin
      next_flash_phase = flash_phase;
      next_flicker_phase = flicker_phase;
      next_slot = slot;
      if (flash_tick)
      begin
         next_flash_phase = !flash_phase;
         if (slot == 8'(SINGLE_SLOTS - 1))
         begin
            next_slot = 8'h00;
         end
         else
         begin
            next_slot = slot + 8'h01;
         end
      end
      if (flicker_tick)
      begin
         next_flicker_phase = !flicker_phase;
      end
   end

   // Phase registers.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flash_phase <= 1'b0;
         flicker_phase <= 1'b0;
         slot <= 8'h00;
      end
      else
      begin
         flash_phase <= next_flash_phase;
         flicker_phase <= next_flicker_phase;
         slot <= next_slot;
      end
   end

   // ----------------------------------------------------------------
   // State decode
   // ----------------------------------------------------------------
   // Maps the state code to a lamp pattern; unknown codes show dark,
   // which is the least misleading answer for an operator.
   function automatic pattern_e decode_state(input logic [3:0] code);
      pattern_e pat;
      pat = PAT_OFF;
      if (code == ST_PREOP)
      begin
         pat = PAT_FLASH;
      end
      else if (code == ST_SAFEOP)
      begin
         pat = PAT_SINGLE;
      end
      else if (code == ST_OP)
      begin
         pat = PAT_ON;
      end
      else if (code == ST_BOOT)
      begin
         pat = PAT_FLICKER;
      end
      return pat;
   endfunction

   pattern_e pattern;

   // ----------------------------------------------------------------
   // Lamp logic
   // ----------------------------------------------------------------
   logic next_period_lamp;
   logic next_ref_lamp;
   logic next_error_lamp;
   logic next_run_lamp;
   logic next_outputs_safe;

   // Next lamp values from the pattern, phases and status inputs.
   always_comb
   begin
      pattern = decode_state(slave_state);
      next_period_lamp = period_lamp ^ period_counted;
      next_ref_lamp = ref_sync;
      next_error_lamp = pdo_error;
      next_outputs_safe = (pattern != PAT_ON);
      case (pattern)
         PAT_OFF: next_run_lamp = 1'b0;
         PAT_FLASH: next_run_lamp = flash_phase;
         PAT_SINGLE: next_run_lamp = (slot == 8'h00);
         PAT_ON: next_run_lamp = 1'b1;
         PAT_FLICKER: next_run_lamp = flicker_phase;
         default: next_run_lamp = 1'b0;
      endcase
   end

   // Lamp registers; outputs come straight from these.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         period_lamp <= LAMP_RESET;
         ref_lamp <= LAMP_RESET;
         error_lamp <= LAMP_RESET;
         run_lamp <= LAMP_RESET;
         outputs_safe <= SAFE_RESET;
      end
      else
      begin
         period_lamp <= next_period_lamp;
         ref_lamp <= next_ref_lamp;
         error_lamp <= next_error_lamp;
         run_lamp <= next_run_lamp;
         outputs_safe <= next_outputs_safe;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   period_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      period_counted |=> (period_lamp != $past(period_lamp)))
      else $error("period lamp did not toggle on a counted period");

   period_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !period_counted |=> $stable(period_lamp))
      else $error("period lamp changed without a counted period");

   error_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 (error_lamp == $past(pdo_error)))
      else $error("error lamp does not follow the error flag");

   init_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
      (slave_state == ST_INIT) |=> !run_lamp)
      else $error("run lamp lit in INIT");

   sequence op_held;
      (slave_state == ST_OP) [*2];
   endsequence

   op_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      op_held |=> run_lamp && !outputs_safe)
      else $error("run lamp not steady in OP");

   safeop_safe_a: assert property (@(posedge clk) disable iff (!rst_n)
      (slave_state == ST_SAFEOP) |=> outputs_safe)
      else $error("outputs not safe in SAFEOP");

   flash_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      (slave_state == ST_PREOP) |=> (run_lamp == $past(flash_phase)))
      else $error("run lamp not flashing in PREOP");

   single_slot_a: assert property (@(posedge clk) disable iff (!rst_n)
      (slave_state == ST_SAFEOP) && (slot != 8'h00) |=> !run_lamp)
      else $error("run lamp lit outside single-flash slot");

   // The lit slot must really light the lamp, not only the dark ones stay dark.
   single_lit_a: assert property (@(posedge clk) disable iff (!rst_n)
      (slave_state == ST_SAFEOP) && (slot == 8'h00) |=> run_lamp)
      else $error("run lamp dark in the single-flash slot");

   flicker_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      (slave_state == ST_BOOT) |=> (run_lamp == $past(flicker_phase)))
      else $error("run lamp not flickering in BOOTSTRAP");

   ref_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##3 (ref_lamp == $past(ref_mark, 3)))
      else $error("reference lamp does not follow the input");

endmodule
`default_nettype wire

// >>> rtl/status_led_pkg.sv
// Purpose: Shared constants for the front-panel diagnostic lamp driver.
// Assumes: 200 MHz system clock.
// Notes: State codes and blink timing live here.
`default_nettype none
package status_led_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   // System clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Flashing half period in milliseconds (on 200 ms, off 200 ms).
   localparam int unsigned FLASH_HALF_MS = 200;
   // Flicker half period in milliseconds (on 50 ms, off 50 ms).
   localparam int unsigned FLICKER_HALF_MS = 50;
   // Cycles in one flashing half period.
   localparam int unsigned FLASH_HALF_CYCLES =
      (FLASH_HALF_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
   // Cycles in one flicker half period.
   localparam int unsigned FLICKER_HALF_CYCLES =
      (FLICKER_HALF_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
   // Single flash: one lit slot out of this many flashing half periods.
   localparam int unsigned SINGLE_SLOTS = 6;

   // ----------------------------------------------------------------
   // Slave state machine state codes
   // ----------------------------------------------------------------
   // Encoded state as delivered by the state machine.
   localparam logic [3:0] ST_INIT = 4'h1;
   localparam logic [3:0] ST_PREOP = 4'h2;
   localparam logic [3:0] ST_BOOT = 4'h3;
   localparam logic [3:0] ST_SAFEOP = 4'h4;
   localparam logic [3:0] ST_OP = 4'h8;

   // Reset values of the lamps.
   localparam logic LAMP_RESET = 1'b0;
   // Reset value of the safe-output flag: safe until the state says otherwise.
   localparam logic SAFE_RESET = 1'b1;

   // Lamp pattern selection, one-hot.
   typedef enum logic [4:0] {
      PAT_OFF = 5'b00001,
      PAT_FLASH = 5'b00010,
      PAT_SINGLE = 5'b00100,
      PAT_ON = 5'b01000,
      PAT_FLICKER = 5'b10000
   } pattern_e;

endpackage
`default_nettype wire

// >>> rtl/blink_timebase.sv
// Purpose: Prescaler producing the slow tick for flash and the fast tick for flicker.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Counts are parameters so a simulation can shorten them.
`timescale 1ns/1ps
`default_nettype none
module blink_timebase
#(
   parameter int unsigned FLASH_CYCLES = status_led_pkg::FLASH_HALF_CYCLES,
   parameter int unsigned FLICKER_CYCLES = status_led_pkg::FLICKER_HALF_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   output logic flash_tick,
   output logic flicker_tick
);
   import status_led_pkg::*;

   // ----------------------------------------------------------------
   // Prescale counters
   // ----------------------------------------------------------------
   // Both counters are 32 bits wide, ample for any sensible period.
   logic [31:0] flash_cnt;
   logic [31:0] next_flash_cnt;
   logic [31:0] flick_cnt;
   logic [31:0] next_flick_cnt;
   logic next_flash_tick;
   logic next_flicker_tick;

   // Flicker must be faster than flashing; refused at elaboration.
   if (FLICKER_CYCLES < 1 || FLASH_CYCLES <= FLICKER_CYCLES)
   begin
      $error("blink_timebase: flicker period must be shorter than flash");
   end

   // Next-value logic: each counter wraps and emits a one-cycle tick.
   always_comb
   begin
      next_flash_tick = 1'b0;
      next_flicker_tick = 1'b0;
      next_flash_cnt = flash_cnt + 32'h00000001;
      next_flick_cnt = flick_cnt + 32'h00000001;
      if (flash_cnt == 32'(FLASH_CYCLES - 1))
      begin
         next_flash_cnt = 32'h00000000;
         next_flash_tick = 1'b1;
      end
      if (flick_cnt == 32'(FLICKER_CYCLES - 1))
      begin
         next_flick_cnt = 32'h00000000;
         next_flicker_tick = 1'b1;
      end
   end

   // Registers only.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flash_cnt <= 32'h00000000;
         flick_cnt <= 32'h00000000;
         flash_tick <= 1'b0;
         flicker_tick <= 1'b0;
      end
      else
      begin
         flash_cnt <= next_flash_cnt;
         flick_cnt <= next_flick_cnt;
         flash_tick <= next_flash_tick;
         flicker_tick <= next_flicker_tick;
      end
   end

   // Flash ticks never come on two consecutive cycles.
   flash_space_a: assert property (@(posedge clk) disable iff (!rst_n)
      flash_tick |=> !flash_tick)
      else $error("flash tick repeated on consecutive cycles");

endmodule
`default_nettype wire

// >>> bench/lamp_observer.sv
// Purpose: Front-panel observer that times how long the run lamp stays lit and dark.
// Assumes: Lamp is sampled on the rising system clock edge.
// Notes: Lengths are in clock cycles; an operator only sees run lengths, not phases.
`timescale 1ns/1ps
`default_nettype none
module lamp_observer
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic lamp,
   output int high_len,
   output int low_len,
   output int age
);
   // Lamp level seen at the previous edge.
   logic prev;

   // ----------------------------------------------------------------
   // Run length timing
   // ----------------------------------------------------------------
   // On each change the finished run is stored under the level it had.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev <= 1'b0;
         age <= 0;
         high_len <= 0;
         low_len <= 0;
      end
      else if (lamp !== prev)
      begin
         // A finished lit run and a finished dark run are kept apart.
         if (prev)
            high_len <= age;
         else
            low_len <= age;
         age <= 1;
         prev <= lamp;
      end
      else
         age <= age + 1;
   end
endmodule
`default_nettype wire

// >>> bench/status_led_indicator_tb_top.sv
// Purpose: Self-checking bench for the diagnostic lamp driver.
// Assumes: Shortened blink counts of 20 and 5 cycles, 4 single-flash slots.
// Notes: Phases run free, so blink checks measure run lengths, not edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module status_led_indicator_tb_top;
   import status_led_pkg::*;
   // Short counts keep each blink check to a few hundred cycles.
   localparam int unsigned FC = 20;
   localparam int unsigned KC = 5;
   localparam int unsigned SL = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic period_counted = 1'b0;
   logic ref_mark = 1'b0;
   logic pdo_error = 1'b0;
   logic [3:0] slave_state = ST_INIT;
   logic period_lamp, ref_lamp, error_lamp, run_lamp, outputs_safe;
   int high_len, low_len, age;
   int err_count = 0;
   int n_compared = 0;

   // ----------------------------------------------------------------
   // Design and observer
   // ----------------------------------------------------------------
   status_led_indicator #(.FLASH_CYCLES(FC), .FLICKER_CYCLES(KC), .SINGLE_SLOTS(SL)) DUT
   (
      .clk(clk), .rst_n(rst_n), .period_counted(period_counted), .ref_mark(ref_mark),
      .pdo_error(pdo_error), .slave_state(slave_state), .period_lamp(period_lamp),
      .ref_lamp(ref_lamp), .error_lamp(error_lamp), .run_lamp(run_lamp),
      .outputs_safe(outputs_safe)
   );
   lamp_observer obs
   (
      .clk(clk), .rst_n(rst_n), .lamp(run_lamp), .high_len(high_len), .low_len(low_len),
      .age(age)
   );

   // 200 MHz clock.
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // Prints the verdict and ends the run.
   task automatic results();
      if (err_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Three back-to-back counted periods give three toggles, then none.
   task automatic t_period();
      logic exp;
      // No period has been counted since reset, so the lamp rests at its reset level.
      exp = LAMP_RESET;
      @(posedge clk) period_counted <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         if (i == 2)
            period_counted <= 1'b0;
         #1;
         exp = ~exp;
         `CHK("period_lamp", exp, period_lamp)
      end
      @(posedge clk);
      #1;
      `CHK("period_lamp idle", exp, period_lamp)
   endtask

   // Error lamp follows the flag one cycle later, both ways.
   task automatic t_error();
      @(posedge clk) pdo_error <= 1'b1;
      @(posedge clk) pdo_error <= 1'b0;
      #1;
      `CHK("error_lamp on", 1'b1, error_lamp)
      @(posedge clk);
      #1;
      `CHK("error_lamp off", 1'b0, error_lamp)
   endtask

   // Reference lamp shows the pin three cycles late, not two.
   task automatic t_ref(input logic lvl);
      @(posedge clk) ref_mark <= lvl;
      repeat (2) @(posedge clk);
      #1;
      `CHK("ref_lamp early", ~lvl, ref_lamp)
      @(posedge clk);
      #1;
      `CHK("ref_lamp", lvl, ref_lamp)
   endtask

   // Steady state: level held at least 200 cycles, safe flag one cycle after entry.
   task automatic t_steady(input logic [3:0] st, input logic lvl, input logic safe);
      @(posedge clk) slave_state <= st;
      @(posedge clk);
      #1;
      `CHK("outputs_safe", safe, outputs_safe)
      repeat (240) @(posedge clk);
      #1;
      `CHK("run_lamp level", lvl, run_lamp)
      `CHK("run_lamp steady", 1'b1, age >= 200)
   endtask

   // Blink state: last complete lit and dark runs have the exact lengths.
   task automatic t_blink(input logic [3:0] st, input int hi, input int lo);
      @(posedge clk) slave_state <= st;
      @(posedge clk);
      #1;
      `CHK("outputs_safe", 1'b1, outputs_safe)
      repeat (240) @(posedge clk);
      #1;
      `CHK("run lit cycles", hi, high_len)
      `CHK("run dark cycles", lo, low_len)
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_period();
      t_error();
      t_ref(1'b1);
      t_ref(1'b0);
      t_steady(ST_INIT, 1'b0, 1'b1);
      t_blink(ST_PREOP, FC, FC);
      t_blink(ST_SAFEOP, FC, FC * (SL - 1));
      t_steady(ST_OP, 1'b1, 1'b0);
      t_blink(ST_BOOT, KC, KC);
      t_steady(4'hF, 1'b0, 1'b1);
      t_steady(ST_OP, 1'b1, 1'b0);
      results();
   end

   // Watchdog: the tests need about 1,700 cycles.
   initial
   begin
      repeat (10000) @(posedge clk);
      err_count++;
      results();
   end
endmodule
`default_nettype wire
